// File: xgp_ports.sv
// Extension bus general purpose ports: port 9 (bidirectional) and port 10 (input).
// Assumes the bus master holds addr/data valid with a one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none
module xgp_ports
   import xgp_pkg::*;
#(
   parameter int WIDTH = 16
) (
   input wire logic core_clk, // System clock, 100 MHz
   input wire logic reset, // Synchronous reset, active high
   input wire logic extPeriphEnable, // Enable bit from system config
   input wire logic port9Enable, // Enable bit from extension control
   input wire logic [xgp_pkg::XGP_ADDR_W-1:0] busAddr, // Bus word address
   input wire logic busWrite, // Write strobe
   input wire logic busRead, // Read strobe
   input wire logic [xgp_pkg::XGP_DATA_W-1:0] busWriteData, // Write data
   output logic [xgp_pkg::XGP_DATA_W-1:0] busReadData, // Registered read data
   output logic busReadValid, // Read data valid pulse
   input wire logic [WIDTH-1:0] port9PinIn, // Port 9 pin levels
   output logic [WIDTH-1:0] port9PinOut, // Port 9 pin drive value
   output logic [WIDTH-1:0] port9PinOe, // Port 9 pin output enable
   input wire logic [WIDTH-1:0] port10PinIn, // Port 10 pin levels
   output logic [WIDTH-1:0] port10InputEnable, // Port 10 input buffer enable
   output logic [2*WIDTH-1:0] analogChannelSel // Analog channel routes, 0..31
);
   import xgp_pkg::*;

   // ************************************************************
   // Decode
   // ************************************************************
   logic blockOn;
   logic [WIDTH-1:0] port9_data_latch;
   logic [WIDTH-1:0] port9_direction_bits;
   logic [WIDTH-1:0] port9_drain_mode_bits;
   logic [WIDTH-1:0] port10_digital_disable;
   logic [WIDTH-1:0] port10_pin_levels;
   logic wrData, wrDataSet, wrDataClr, wrDir, wrDirSet, wrDirClr;
   logic wrDrn, wrDrnSet, wrDrnClr, wrDis;
   // One enable pair gates both ports; with either bit low, writes are dropped and
   // reads still pulse valid with zero data, so port 10 reads zero while port 9 is switched off
   // enable gating
   assign blockOn = extPeriphEnable && port9Enable;
   assign wrData = busWrite && blockOn && (busAddr == XGP_DATA_OFS);
   assign wrDataSet = busWrite && blockOn && (busAddr == XGP_DATA_SET_OFS);
   assign wrDataClr = busWrite && blockOn && (busAddr == XGP_DATA_CLR_OFS);
   assign wrDir = busWrite && blockOn && (busAddr == XGP_DIR_OFS);
   assign wrDirSet = busWrite && blockOn && (busAddr == XGP_DIR_SET_OFS);
   assign wrDirClr = busWrite && blockOn && (busAddr == XGP_DIR_CLR_OFS);
   assign wrDrn = busWrite && blockOn && (busAddr == XGP_DRN_OFS);
   assign wrDrnSet = busWrite && blockOn && (busAddr == XGP_DRN_SET_OFS);
   assign wrDrnClr = busWrite && blockOn && (busAddr == XGP_DRN_CLR_OFS);
   assign wrDis = busWrite && blockOn && (busAddr == XGP_DIS_OFS);

   // ************************************************************
   // Port 9 registers
   // ************************************************************
   // Three identical registers; the strobes are exclusive by address
   // data latch set/clear
   xgp_setclr_reg #(.WIDTH(WIDTH), .RESET_VALUE(XGP_DATA_RST)) dataReg (
      .core_clk(core_clk),
      .reset(reset),
      .writeWord(wrData),
      .writeSet(wrDataSet),
      .writeClear(wrDataClr),
      .writeData(busWriteData[WIDTH-1:0]),
      .value(port9_data_latch)
   );
   xgp_setclr_reg #(.WIDTH(WIDTH), .RESET_VALUE(XGP_DIR_RST)) dirReg (
      .core_clk(core_clk),
      .reset(reset),
      .writeWord(wrDir),
      .writeSet(wrDirSet),
      .writeClear(wrDirClr),
      .writeData(busWriteData[WIDTH-1:0]),
      .value(port9_direction_bits)
   );
   xgp_setclr_reg #(.WIDTH(WIDTH), .RESET_VALUE(XGP_DRN_RST)) drnReg (
      .core_clk(core_clk),
      .reset(reset),
      .writeWord(wrDrn),
      .writeSet(wrDrnSet),
      .writeClear(wrDrnClr),
      .writeData(busWriteData[WIDTH-1:0]),
      .value(port9_drain_mode_bits)
   );

   // ************************************************************
   // Port 9 pin drivers
   // ************************************************************
   // Per-line driver select, combinational so pins follow the registers at once
   // Open drain never drives high; a released line floats to the board pull-up
   // direction drives enable
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         if (port9_drain_mode_bits[i]) begin
            port9PinOut[i] = 1'b0;
            port9PinOe[i] = port9_direction_bits[i] && !port9_data_latch[i];
         end else begin
            port9PinOut[i] = port9_data_latch[i];
            port9PinOe[i] = port9_direction_bits[i];
         end
      end
   end

   // ************************************************************
   // Port 10
   // ************************************************************
   // digital-disable register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         port10_digital_disable <= XGP_DIS_RST;
      end else if (wrDis) begin
         port10_digital_disable <= busWriteData[WIDTH-1:0];
      end
   end
   // Buffer enables are the inverse of the disable bits
   assign port10InputEnable = ~port10_digital_disable;
   assign port10_pin_levels = port10PinIn & port10InputEnable;
   // Analog path skips the digital buffer, so disabling it never cuts a channel
   // line y is channel 16+y, no setup needed
   assign analogChannelSel = {port10PinIn, {XGP_ANALOG_BASE{1'b0}}};

   // ************************************************************
   // Read path
   // ************************************************************
   // Read data are registered and drop to zero between reads, so a stale
   // word never stands on the bus
   // port 10 data has no write decode, so writes vanish
   always_ff @(posedge core_clk) begin
      if (reset) begin
         busReadData <= '0;
         busReadValid <= 1'b0;
      end else begin
         busReadValid <= busRead;
         if (!busRead || !blockOn) begin
            busReadData <= '0;
         end else if (busAddr == XGP_DATA_OFS) begin
            busReadData <= port9_data_latch;
         end else if (busAddr == XGP_DIR_OFS) begin
            busReadData <= port9_direction_bits;
         end else if (busAddr == XGP_DRN_OFS) begin
            busReadData <= port9_drain_mode_bits;
         end else if (busAddr == XGP_P10_OFS) begin
            busReadData <= port10_pin_levels;
         end else if (busAddr == XGP_DIS_OFS) begin
            busReadData <= port10_digital_disable;
         end else begin
            busReadData <= '0;
         end
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   dir_set_a: assert property (@(posedge core_clk) disable iff (reset)
      wrDirSet |=> ((port9_direction_bits & $past(busWriteData)) == $past(busWriteData)))
      else $error("direction set lost bits");
   dir_clear_a: assert property (@(posedge core_clk) disable iff (reset)
      wrDirClr |=> ((port9_direction_bits & $past(busWriteData)) == '0))
      else $error("direction clear kept bits");
   drn_set_a: assert property (@(posedge core_clk) disable iff (reset)
      wrDrnSet |=> (port9_drain_mode_bits == ($past(port9_drain_mode_bits) | $past(busWriteData))))
      else $error("drain set wrong");
   drn_clear_a: assert property (@(posedge core_clk) disable iff (reset)
      wrDrnClr |=> (port9_drain_mode_bits == ($past(port9_drain_mode_bits) & ~$past(busWriteData))))
      else $error("drain clear wrong");
   input_hiz_a: assert property (@(posedge core_clk) disable iff (reset)
      ((port9PinOe & ~port9_direction_bits) == '0))
      else $error("input line driven");
   drain_high_a: assert property (@(posedge core_clk) disable iff (reset)
      ((port9PinOe & port9_drain_mode_bits & port9PinOut) == '0))
      else $error("open drain drove high");
   gate_off_a: assert property (@(posedge core_clk) disable iff (reset)
      (!blockOn && busWrite) |=> $stable(port10_digital_disable))
      else $error("write while disabled");
   setclr_zero_a: assert property (@(posedge core_clk) disable iff (reset)
      (busRead && (busAddr == XGP_DIR_SET_OFS)) |=> (busReadValid && busReadData == '0))
      else $error("set register read nonzero");
   p10_read_a: assert property (@(posedge core_clk) disable iff (reset)
      (busRead && blockOn && busAddr == XGP_P10_OFS) |=> (busReadData == $past(port10_pin_levels)))
      else $error("pin level read wrong");
   // Digital-disable write reaches the buffer enables
   dis_write_a: assert property (@(posedge core_clk) disable iff (reset)
      wrDis |=> (port10InputEnable == ~$past(busWriteData[WIDTH-1:0])))
      else $error("input enable not updated");
   // A disabled buffer never shows a high level on the read path
   dis_block_a: assert property (@(posedge core_clk) disable iff (reset)
      (busRead && blockOn && busAddr == XGP_P10_OFS) |=>
      ((busReadData & $past(port10_digital_disable)) == '0))
      else $error("disabled input read high");

   // ************************************************************
   // Checks: enables and word access
   // ************************************************************
   // Gated writes leave every port 9 register alone
   p9_gate_a: assert property (@(posedge core_clk) disable iff (reset)
      (!blockOn && busWrite) |=>
      ($stable(port9_direction_bits) && $stable(port9_drain_mode_bits)
      && $stable(port9_data_latch)))
      else $error("port 9 written while disabled");
   // Gated reads still answer, with zero data
   read_gate_a: assert property (@(posedge core_clk) disable iff (reset)
      (busRead && !blockOn) |=> (busReadValid && busReadData == '0))
      else $error("gated read not zero");
   // A whole-word write replaces the direction word
   word_dir_a: assert property (@(posedge core_clk) disable iff (reset)
      wrDir |=> (port9_direction_bits == $past(busWriteData[WIDTH-1:0])))
      else $error("direction word write lost");
   // A whole-word write replaces the drain-mode word
   word_drn_a: assert property (@(posedge core_clk) disable iff (reset)
      wrDrn |=> (port9_drain_mode_bits == $past(busWriteData[WIDTH-1:0])))
      else $error("drain word write lost");
   // Port 10 data writes touch no state at all
   p10_write_a: assert property (@(posedge core_clk) disable iff (reset)
      (busWrite && busAddr == XGP_P10_OFS) |=>
      ($stable(port10_digital_disable) && $stable(port9_direction_bits)
      && $stable(port9_drain_mode_bits) && $stable(port9_data_latch)))
      else $error("port 10 write changed state");

   // ************************************************************
   // Checks: data latch and read side effects
   // ************************************************************
   // Data latch set register
   data_set_a: assert property (@(posedge core_clk) disable iff (reset)
      wrDataSet |=>
      (port9_data_latch == ($past(port9_data_latch) | $past(busWriteData[WIDTH-1:0]))))
      else $error("data set wrong");
   // Data latch clear register
   data_clear_a: assert property (@(posedge core_clk) disable iff (reset)
      wrDataClr |=>
      (port9_data_latch == ($past(port9_data_latch) & ~$past(busWriteData[WIDTH-1:0]))))
      else $error("data clear wrong");
   // Other set and clear offsets also read as zero
   setclr_other_a: assert property (@(posedge core_clk) disable iff (reset)
      (busRead && (busAddr == XGP_DIR_CLR_OFS || busAddr == XGP_DRN_SET_OFS
      || busAddr == XGP_DRN_CLR_OFS || busAddr == XGP_DATA_SET_OFS
      || busAddr == XGP_DATA_CLR_OFS)) |=> (busReadValid && busReadData == '0))
      else $error("clear register read nonzero");
   // Reads never disturb the registers they look at
   read_quiet_a: assert property (@(posedge core_clk) disable iff (reset)
      (busRead && !busWrite) |=>
      ($stable(port9_direction_bits) && $stable(port9_drain_mode_bits)
      && $stable(port9_data_latch) && $stable(port10_digital_disable)))
      else $error("read changed a register");

   // ************************************************************
   // Checks: reset values and pin drivers
   // ************************************************************
   // Reset leaves every line an input
   dir_reset_a: assert property (@(posedge core_clk) disable iff (reset)
      $fell(reset) |-> (port9_direction_bits == XGP_DIR_RST && port9PinOe == '0))
      else $error("direction not reset");
   // Reset leaves every driver push-pull
   drn_reset_a: assert property (@(posedge core_clk) disable iff (reset)
      $fell(reset) |-> (port9_drain_mode_bits == XGP_DRN_RST))
      else $error("drain mode not reset");
   // Reset leaves every port 10 buffer on
   dis_reset_a: assert property (@(posedge core_clk) disable iff (reset)
      $fell(reset) |-> (port10_digital_disable == XGP_DIS_RST
      && port10InputEnable == ~XGP_DIS_RST))
      else $error("digital disable not reset");
   // Push-pull outputs always drive
   push_drive_a: assert property (@(posedge core_clk) disable iff (reset)
      ((port9_direction_bits & ~port9_drain_mode_bits & ~port9PinOe) == '0))
      else $error("output line not driven");
   // Push-pull outputs carry the latch
   push_value_a: assert property (@(posedge core_clk) disable iff (reset)
      (((port9PinOut ^ port9_data_latch) & ~port9_drain_mode_bits) == '0))
      else $error("push-pull value wrong");
   // Open drain lines release when the latch is high
   drain_release_a: assert property (@(posedge core_clk) disable iff (reset)
      ((port9PinOe & port9_drain_mode_bits & port9_data_latch) == '0))
      else $error("open drain held low");
endmodule
`default_nettype wire

// File: xgp_pkg.sv
// Package for the extension bus port block: offsets, reset values, widths.
// Assumes a 16-bit extension bus with word addresses as printed.
`default_nettype none
package xgp_pkg;
   localparam int XGP_ADDR_W = 16;
   localparam int XGP_DATA_W = 16;
   localparam logic [15:0] XGP_DIR_OFS = 16'hc200;
   localparam logic [15:0] XGP_DIR_SET_OFS = 16'hc202;
   localparam logic [15:0] XGP_DIR_CLR_OFS = 16'hc204;
   localparam logic [15:0] XGP_DRN_OFS = 16'hc300;
   localparam logic [15:0] XGP_DRN_SET_OFS = 16'hc302;
   localparam logic [15:0] XGP_DRN_CLR_OFS = 16'hc304;
   localparam logic [15:0] XGP_P10_OFS = 16'hc380;
   localparam logic [15:0] XGP_DIS_OFS = 16'hc382;
   localparam logic [15:0] XGP_DATA_OFS = 16'hc100;
   localparam logic [15:0] XGP_DATA_SET_OFS = 16'hc102;
   localparam logic [15:0] XGP_DATA_CLR_OFS = 16'hc104;
   localparam logic [15:0] XGP_DIR_RST = 16'h0000;
   localparam logic [15:0] XGP_DRN_RST = 16'h0000;
   localparam logic [15:0] XGP_DIS_RST = 16'h0000;
   localparam logic [15:0] XGP_DATA_RST = 16'h0000;
   localparam int XGP_ANALOG_BASE = 16;
endpackage
`default_nettype wire

// File: xgp_setclr_reg.sv
// One 16-bit register with whole-word write, write-one set and write-one clear.
// Assumes at most one of the three strobes is high in a cycle.
`timescale 1ns/1ps
`default_nettype none
module xgp_setclr_reg #(
   parameter int WIDTH = 16,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic core_clk, // System clock
   input wire logic reset, // Synchronous reset
   input wire logic writeWord, // Whole-word write strobe
   input wire logic writeSet, // Set-register write strobe
   input wire logic writeClear, // Clear-register write strobe
   input wire logic [WIDTH-1:0] writeData, // Written data
   output logic [WIDTH-1:0] value // Register contents
);
   // Ones set or clear, zeros leave bits alone
   always_ff @(posedge core_clk) begin
      if (reset) begin
         value <= RESET_VALUE;
      end else if (writeWord) begin
         value <= writeData;
      end else if (writeSet) begin
         value <= value | writeData;
      end else if (writeClear) begin
         value <= value & ~writeData;
      end
   end
endmodule
`default_nettype wire

// File: xgp_pin_model.sv
// Pin-side model: port 9 wires and port 10 input levels.
// Assumes the bench sets the outside levels; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module xgp_pin_model (
   input wire logic [15:0] port9PinOut, // Design drive value
   input wire logic [15:0] port9PinOe, // Design drive enable
   input wire logic [15:0] port9Ext, // Level from outside
   input wire logic [15:0] port10Ext, // Source level on port 10
   output logic [15:0] port9PinIn, // Resolved port 9 wire
   output logic [15:0] port10PinIn // Port 10 pin levels
);
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         port9PinIn[i] = port9PinOe[i] ? port9PinOut[i] : port9Ext[i];
      end
   end
   assign port10PinIn = port10Ext;
endmodule
`default_nettype wire

// File: tb_xgp_ports.sv
// Self-checking bench for the extension bus port registers.
// Assumes the pin model on the far side; one-cycle bus strobes.
`timescale 1ns/1ps
`default_nettype none
module tb_xgp_ports;
   import xgp_pkg::*;
   logic core_clk = 0, reset = 1, extPeriphEnable = 1, port9Enable = 1;
   logic busWrite = 0, busRead = 0, busReadValid;
   logic [15:0] busAddr = '0, busWriteData = '0, busReadData, p9Out, p9Oe, p9In, p10In;
   logic [15:0] p9Ext = 16'h0000, p10Ext = 16'ha5c3, inEn;
   logic [31:0] anaSel;
   logic [15:0] scOfs [6] = '{XGP_DIR_SET_OFS, XGP_DIR_CLR_OFS, XGP_DRN_SET_OFS,
      XGP_DRN_CLR_OFS, XGP_DATA_SET_OFS, XGP_DATA_CLR_OFS};
   int error_cnt = 0, num_checks = 0;
   xgp_ports xgp_ports_inst (.core_clk(core_clk), .reset(reset),
      .extPeriphEnable(extPeriphEnable), .port9Enable(port9Enable), .busAddr(busAddr),
      .busWrite(busWrite), .busRead(busRead), .busWriteData(busWriteData),
      .busReadData(busReadData), .busReadValid(busReadValid), .port9PinIn(p9In),
      .port9PinOut(p9Out), .port9PinOe(p9Oe), .port10PinIn(p10In),
      .port10InputEnable(inEn), .analogChannelSel(anaSel));
   xgp_pin_model xgp_pin_model_inst (.port9PinOut(p9Out), .port9PinOe(p9Oe),
      .port9Ext(p9Ext), .port10Ext(p10Ext), .port9PinIn(p9In), .port10PinIn(p10In));
   // Clock, 10 ns period
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Write; an idle edge follows so strobes never toggle twice in one step
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      busAddr = a;
      busWriteData = d;
      busWrite = 1;
      @(posedge core_clk) #1;
      busWrite = 0;
      @(posedge core_clk) #1;
   endtask
   // Read; data and valid land one edge after the strobe
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      busAddr = a;
      busRead = 1;
      @(posedge core_clk) #1;
      busRead = 0;
      chk(busReadValid, 1);
      chk(busReadData, exp);
      @(posedge core_clk) #1;
      chk(busReadValid, 0);
   endtask
   task automatic t_reset;
      chk(p9Oe, 0);
      chk(inEn, 16'hffff);
      rd(XGP_DIR_OFS, XGP_DIR_RST);
      rd(XGP_DRN_OFS, XGP_DRN_RST);
      rd(XGP_DIS_OFS, XGP_DIS_RST);
      rd(XGP_DATA_OFS, XGP_DATA_RST);
   endtask
   // Mid-run reset must undo every earlier write
   task automatic t_rerun;
      reset = 1;
      repeat (2) @(posedge core_clk) #1;
      reset = 0;
      t_reset();
   endtask
   task automatic t_dir;
      wr(XGP_DIR_OFS, 16'h1234);
      chk(p9Oe, 16'h1234);
      wr(XGP_DIR_SET_OFS, 16'h00f0);
      rd(XGP_DIR_OFS, 16'h12f4);
      wr(XGP_DIR_CLR_OFS, 16'h0204);
      chk(p9Oe, 16'h10f0);
      for (int i = 0; i < 6; i++) rd(scOfs[i], 16'h0000);
      rd(XGP_DIR_OFS, 16'h10f0);
   endtask
   task automatic t_drain;
      wr(XGP_DIR_OFS, 16'h00ff);
      wr(XGP_DRN_OFS, 16'h0f00);
      wr(XGP_DRN_SET_OFS, 16'h000f);
      wr(XGP_DRN_CLR_OFS, 16'h0f00);
      rd(XGP_DRN_OFS, 16'h000f);
      wr(XGP_DATA_OFS, 16'h0015);
      wr(XGP_DATA_SET_OFS, 16'h0020);
      wr(XGP_DATA_CLR_OFS, 16'h0004);
      rd(XGP_DATA_OFS, 16'h0031);
      chk(p9Oe, 16'h00fe);
      chk(p9Out & p9Oe, 16'h0030);
   endtask
   task automatic t_port10;
      rd(XGP_P10_OFS, 16'ha5c3);
      chk(anaSel, 32'ha5c30000);
      wr(XGP_P10_OFS, 16'hffff);
      rd(XGP_P10_OFS, 16'ha5c3);
      rd(XGP_DIS_OFS, 16'h0000);
      wr(XGP_DIS_OFS, 16'h00ff);
      chk(inEn, 16'hff00);
      p10Ext = 16'h5a3c;
      rd(XGP_P10_OFS, 16'h5a00);
      chk(anaSel, 32'h5a3c0000);
   endtask
   task automatic t_enable;
      extPeriphEnable = 0;
      wr(XGP_DIR_SET_OFS, 16'hffff);
      rd(XGP_DIR_OFS, 16'h0000);
      extPeriphEnable = 1;
      port9Enable = 0;
      wr(XGP_DIS_OFS, 16'h0000);
      rd(XGP_P10_OFS, 16'h0000);
      port9Enable = 1;
      rd(XGP_DIR_OFS, 16'h00ff);
      rd(XGP_DIS_OFS, 16'h00ff);
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Main sequence: two reset cycles, then scenarios
   initial begin
      repeat (2) @(posedge core_clk);
      #1 reset = 0;
      t_reset();
      t_dir();
      t_drain();
      t_port10();
      t_enable();
      t_rerun();
      tally_and_finish();
   end
endmodule
`default_nettype wire
